// >>> atctr_regs.v
// Register bank for transmit byte count high, conversion result, tuning result and tuning override.
//
// Functional notes
// - Count-high register holds upper eight count bits.
// - Count-high clears on reset, defaults, clear.
// - Conversion and tuning results clear on reset, defaults.
// - Latest conversion result readable, writes ignored.
// - Tuning result stored in bits seven to four.
// - Bit three flags failed antenna tuning.
// - Source bit selects calibration or software trim.
// - Each 1 trim bit switches both transistors.
// - Override register: software trim bits six-three.
// - Count combines low register bits seven, six.
`timescale 1ns/1ps
`include "atctr_map.vh"
module atctr_regs #(
  parameter ADDR_W = `ATCTR_ADDR_W,
  parameter TRIM_W = `ATCTR_TRIM_W
) (
  sys_clk,
  rst,
  regWrEn,
  regRdEn,
  regAddr,
  regWrData,
  regRdData,
  setDefaultCmd,
  clearCmd,
  countLowBits,
  adcDone,
  adcData,
  calDone,
  calTrim,
  calFail,
  txByteCount,
  tuningSwitchPinsA,
  tuningSwitchPinsB
);
  input sys_clk;
  input rst;
  input regWrEn;
  input regRdEn;
  input [ADDR_W-1:0] regAddr;
  input [7:0] regWrData;
  output [7:0] regRdData;
  input setDefaultCmd;
  input clearCmd;
  input [1:0] countLowBits;
  input adcDone;
  input [7:0] adcData;
  input calDone;
  input [TRIM_W-1:0] calTrim;
  input calFail;
  output [9:0] txByteCount;
  output [TRIM_W-1:0] tuningSwitchPinsA;
  output [TRIM_W-1:0] tuningSwitchPinsB;

  reg [7:0] countHigh_ff;
  reg [7:0] adcResult_ff;
  reg [TRIM_W-1:0] tuneTrim_ff;
  reg tuneErr_ff;
  reg srcSel_ff;
  reg [TRIM_W-1:0] swTrim_ff;
  reg [7:0] rdData_ff;
  reg [9:0] txCount_ff;
  reg [7:0] nxt_rdData;
  reg [7:0] nxt_countHigh;
  reg [7:0] nxt_adcResult;
  reg [TRIM_W-1:0] nxt_tuneTrim;
  reg nxt_tuneErr;
  reg nxt_srcSel;
  reg [TRIM_W-1:0] nxt_swTrim;
  wire [9:0] nxt_txCount;
  wire wrCountHigh;
  wire wrOverride;
  wire restoreAll;
  wire clearCount;

  // Address match used by both the write and the read path.
  function hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // Write strobes decoded once; a write to a read-only or unmapped offset matches none and is dropped.
  assign wrCountHigh = regWrEn & hit(regAddr, `ATCTR_OFF_COUNT_HIGH);
  assign wrOverride = regWrEn & hit(regAddr, `ATCTR_OFF_OVERRIDE);
  assign restoreAll = setDefaultCmd;
  assign clearCount = setDefaultCmd | clearCmd;

  // Next count-high value; clear and defaults outrank a same-cycle write.
  always @* begin
    nxt_countHigh = countHigh_ff;
    if (clearCount) begin
      nxt_countHigh = `ATCTR_RST_BYTE;
    end else if (wrCountHigh) begin
      nxt_countHigh = regWrData;
    end
  end

  // Count-high storage.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      countHigh_ff <= `ATCTR_RST_BYTE;
    end else begin
      countHigh_ff <= nxt_countHigh;
    end
  end

  // Next conversion result; it follows the converter only, so bus writes never reach it.
  always @* begin
    nxt_adcResult = adcResult_ff;
    if (restoreAll) begin
      nxt_adcResult = `ATCTR_RST_BYTE;
    end else if (adcDone) begin
      nxt_adcResult = adcData;
    end
  end

  // Conversion result storage.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      adcResult_ff <= `ATCTR_RST_BYTE;
    end else begin
      adcResult_ff <= nxt_adcResult;
    end
  end

  // Next calibration result; trim and failure flag are captured together, and defaults win over completion.
  always @* begin
    nxt_tuneTrim = tuneTrim_ff;
    nxt_tuneErr = tuneErr_ff;
    if (restoreAll) begin
      nxt_tuneTrim = `ATCTR_RST_NIB;
      nxt_tuneErr = 1'h0;
    end else if (calDone) begin
      nxt_tuneTrim = calTrim;
      nxt_tuneErr = calFail;
    end
  end

  // Calibration result storage.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tuneTrim_ff <= `ATCTR_RST_NIB;
      tuneErr_ff <= 1'h0;
    end else begin
      tuneTrim_ff <= nxt_tuneTrim;
      tuneErr_ff <= nxt_tuneErr;
    end
  end

  // Next override value; the clear command leaves it alone, only defaults reset it.
  always @* begin
    nxt_srcSel = srcSel_ff;
    nxt_swTrim = swTrim_ff;
    if (restoreAll) begin
      nxt_srcSel = 1'h0;
      nxt_swTrim = `ATCTR_RST_NIB;
    end else if (wrOverride) begin
      nxt_srcSel = regWrData[`ATCTR_SRC_SEL_BIT];
      nxt_swTrim = regWrData[`ATCTR_SW_TRIM_MSB:`ATCTR_SW_TRIM_LSB];
    end
  end

  // Override storage; unused low bits of a write are simply not kept.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      srcSel_ff <= 1'h0;
      swTrim_ff <= `ATCTR_RST_NIB;
    end else begin
      srcSel_ff <= nxt_srcSel;
      swTrim_ff <= nxt_swTrim;
    end
  end

  // Read multiplexer; unused bits and unmapped offsets return zero.
  always @* begin
    nxt_rdData = `ATCTR_RST_BYTE;
    if (hit(regAddr, `ATCTR_OFF_COUNT_HIGH)) begin
      nxt_rdData = countHigh_ff;
    end else if (hit(regAddr, `ATCTR_OFF_ADC)) begin
      nxt_rdData = adcResult_ff;
    end else if (hit(regAddr, `ATCTR_OFF_TUNE)) begin
      nxt_rdData = {tuneTrim_ff, tuneErr_ff, 3'h0};
    end else if (hit(regAddr, `ATCTR_OFF_OVERRIDE)) begin
      nxt_rdData = {srcSel_ff, swTrim_ff, 3'h0};
    end
  end

  // Read data is held until the next read so the caller may sample late.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData_ff <= `ATCTR_RST_BYTE;
    end else if (regRdEn) begin
      rdData_ff <= nxt_rdData;
    end
  end

  // Count-low supplies the two bottom bits; a ten-bit field cannot exceed 1023, so no range check is kept.
  assign nxt_txCount = {countHigh_ff, countLowBits};

  // Full ten-bit count, registered so the output comes straight from a flip-flop.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txCount_ff <= 10'h000;
    end else begin
      txCount_ff <= nxt_txCount;
    end
  end

  assign regRdData = rdData_ff;
  assign txByteCount = txCount_ff;

  atctr_trim_drive #(
    .TRIM_W(TRIM_W)
  ) u_trim (
    .sys_clk(sys_clk),
    .rst(rst),
    .srcSel(srcSel_ff),
    .calTrim(tuneTrim_ff),
    .swTrim(swTrim_ff),
    .tuningSwitchPinsA(tuningSwitchPinsA),
    .tuningSwitchPinsB(tuningSwitchPinsB)
  );
endmodule // atctr_regs

// >>> atctr_map.vh
// Register offsets, field positions and reset values for the antenna trim and transmit count bank.
`ifndef ATCTR_MAP_VH
`define ATCTR_MAP_VH
`define ATCTR_ADDR_W 6
`define ATCTR_OFF_COUNT_LOW 6'h0B
`define ATCTR_OFF_COUNT_HIGH 6'h0C
`define ATCTR_OFF_ADC 6'h0D
`define ATCTR_OFF_TUNE 6'h0E
`define ATCTR_OFF_OVERRIDE 6'h0F
`define ATCTR_RST_BYTE 8'h00
`define ATCTR_RST_NIB 4'h0
`define ATCTR_TUNE_ERR_BIT 3
`define ATCTR_SRC_SEL_BIT 7
`define ATCTR_SW_TRIM_MSB 6
`define ATCTR_SW_TRIM_LSB 3
`define ATCTR_LOW_CNT_MSB 7
`define ATCTR_LOW_CNT_LSB 6
`define ATCTR_TRIM_W 4
`endif

// >>> atctr_trim_drive.v
// Tuning switch source selection and pin drive for both switch groups.
`timescale 1ns/1ps
`include "atctr_map.vh"
module atctr_trim_drive #(
  parameter TRIM_W = `ATCTR_TRIM_W
) (
  sys_clk,
  rst,
  srcSel,
  calTrim,
  swTrim,
  tuningSwitchPinsA,
  tuningSwitchPinsB
);
  input sys_clk;
  input rst;
  input srcSel;
  input [TRIM_W-1:0] calTrim;
  input [TRIM_W-1:0] swTrim;
  output [TRIM_W-1:0] tuningSwitchPinsA;
  output [TRIM_W-1:0] tuningSwitchPinsB;

  reg [TRIM_W-1:0] pinsA_ff;
  reg [TRIM_W-1:0] pinsB_ff;
  wire [TRIM_W-1:0] nxt_pins;

  // Select calibration result or software bits; a 1 switches the transistor on.
  assign nxt_pins = srcSel ? swTrim : calTrim;

  // Registered so the pins never glitch while the source bit changes.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinsA_ff <= {TRIM_W{1'b0}};
      pinsB_ff <= {TRIM_W{1'b0}};
    end else begin
      pinsA_ff <= nxt_pins;
      pinsB_ff <= nxt_pins;
    end
  end

  assign tuningSwitchPinsA = pinsA_ff;
  assign tuningSwitchPinsB = pinsB_ff;
endmodule // atctr_trim_drive

// >>> atctr_mcu.sv
// Microcontroller model issuing register writes and reads.
`timescale 1ns/1ps
module atctr_mcu (input wire sys_clk, input wire [7:0] regRdData, output reg regWrEn = 1'b0,
  output reg regRdEn = 1'b0, output reg [5:0] regAddr = 6'h3F, output reg [7:0] regWrData = 8'hFF);
  // One-cycle strobes; a released bus shows inverted values so stale data never passes for live.
  task wr(input [5:0] a, input [7:0] d); // Count-high writes keep the byte count within ten bits
    begin
      @(negedge sys_clk) {regWrEn, regAddr, regWrData} = {1'b1, a, d};
      @(negedge sys_clk) {regWrEn, regAddr, regWrData} = {1'b0, ~a, ~d};
    end
  endtask
  task rd(input [5:0] a, output [7:0] d);
    begin
      @(negedge sys_clk) {regRdEn, regAddr} = {1'b1, a};
      @(negedge sys_clk) {regRdEn, regAddr} = {1'b0, ~a};
      d = regRdData;
    end
  endtask
endmodule // atctr_mcu

// >>> atctr_chk.sv
// Assertion checker for the register bank ports.
`timescale 1ns/1ps
module atctr_chk (input wire sys_clk, rst, regWrEn, regRdEn, setDefaultCmd, clearCmd, input wire [5:0] regAddr,
  input wire [7:0] regWrData, regRdData, input wire [1:0] countLowBits, input wire [9:0] txByteCount,
  input wire [3:0] tuningSwitchPinsA, tuningSwitchPinsB);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Outputs are registered, so effects are checked one or two edges after their cause.
  a_pins_twin: assert property (tuningSwitchPinsA == tuningSwitchPinsB) else $error("pins");
  a_count_low: assert property (txByteCount[1:0] == $past(countLowBits)) else $error("low");
  a_count_wr: assert property (regWrEn && regAddr == 6'h0C && !clearCmd && !setDefaultCmd |=> ##1
    txByteCount[9:2] == $past(regWrData, 2)) else $error("count");
  a_rd_void: assert property (regRdEn && (regAddr < 6'h0C || regAddr > 6'h0F) |=>
    !regRdData) else $error("map");
  a_rd_unused: assert property (regRdEn && regAddr[5:1] == 5'h07 |=>
    !regRdData[2:0]) else $error("unused");
  a_rd_hold: assert property (!regRdEn |=> $stable(regRdData)) else $error("hold");
  a_clr_count: assert property (clearCmd || setDefaultCmd |=> ##1 !txByteCount[9:2]) else $error("clr");
  a_def_pins: assert property (setDefaultCmd |=> ##1 !tuningSwitchPinsA) else $error("dflt");
endmodule // atctr_chk
bind atctr_regs atctr_chk chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .regWrEn(regWrEn),
  .regRdEn(regRdEn),
  .setDefaultCmd(setDefaultCmd),
  .clearCmd(clearCmd),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regRdData(regRdData),
  .countLowBits(countLowBits),
  .txByteCount(txByteCount),
  .tuningSwitchPinsA(tuningSwitchPinsA),
  .tuningSwitchPinsB(tuningSwitchPinsB)
);

// >>> atctr_regs_bench.sv
// Self-checking bench for the register bank.
`timescale 1ns/1ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module atctr_regs_bench;
  reg sys_clk = 1'b0, rst = 1'b1, setDefaultCmd = 1'b0, clearCmd = 1'b0, adcDone = 1'b0, calDone = 1'b0;
  reg calFail = 1'b1;
  reg [1:0] countLowBits = 2'h0;
  reg [3:0] calTrim = 4'hA;
  reg [7:0] adcData = 8'h81, rdVal;
  wire regWrEn, regRdEn;
  wire [5:0] regAddr;
  wire [7:0] regWrData, regRdData;
  wire [9:0] txByteCount;
  wire [3:0] tuningSwitchPinsA, tuningSwitchPinsB;
  integer mismatches = 0, numChecks = 0, i;
  atctr_regs dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regRdData(regRdData),
    .setDefaultCmd(setDefaultCmd),
    .clearCmd(clearCmd),
    .countLowBits(countLowBits),
    .adcDone(adcDone),
    .adcData(adcData),
    .calDone(calDone),
    .calTrim(calTrim),
    .calFail(calFail),
    .txByteCount(txByteCount),
    .tuningSwitchPinsA(tuningSwitchPinsA),
    .tuningSwitchPinsB(tuningSwitchPinsB)
  );
  atctr_mcu mcu (
    .sys_clk(sys_clk),
    .regRdData(regRdData),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regAddr(regAddr),
    .regWrData(regWrData)
  );
  // Free-running 40 MHz clock.
  initial forever #12.5 sys_clk = ~sys_clk;
  task rc(input [5:0] a, input [7:0] e);
    begin mcu.rd(a, rdVal); `CHK(rdVal, e) end
  endtask
  // Pulses one of the command or capture strobes for a single cycle.
  task pulse(input [3:0] s);
    begin
      {setDefaultCmd, clearCmd, adcDone, calDone} = s;
      @(negedge sys_clk) {setDefaultCmd, clearCmd, adcDone, calDone} = 4'h0;
    end
  endtask
  task t_reset;
    begin
      `CHK(txByteCount, 10'h000)
      `CHK(tuningSwitchPinsA, 4'h0)
      for (i = 12; i < 16; i++) rc(i[5:0], 8'h00);
    end
  endtask
  task t_trim;
    begin
      pulse(4'h1);
      rc(6'h0E, 8'hA8);
      `CHK(tuningSwitchPinsA, 4'hA)
      mcu.wr(6'h0F, 8'hFF);
      rc(6'h0F, 8'hF8);
      `CHK(tuningSwitchPinsB, 4'hF)
      rc(6'h20, 8'h00);
    end
  endtask
  // Defaults clear both results; a later passing calibration drives the pins again.
  task t_adc;
    begin
      pulse(4'h2);
      mcu.wr(6'h0D, 8'hFF);
      rc(6'h0D, 8'h81);
      pulse(4'h8);
      rc(6'h0D, 8'h00);
      rc(6'h0E, 8'h00);
      rc(6'h0F, 8'h00);
      {calTrim, calFail} = {4'h5, 1'h0};
      pulse(4'h1);
      rc(6'h0E, 8'h50);
      `CHK(tuningSwitchPinsA, 4'h5)
    end
  endtask
  task t_count;
    begin
      countLowBits = 2'h2;
      mcu.wr(6'h0C, 8'hA5);
      @(negedge sys_clk);
      `CHK(txByteCount, 10'h296)
      rc(6'h0C, 8'hA5);
      pulse(4'h4);
      @(negedge sys_clk);
      `CHK(txByteCount, 10'h002)
      mcu.wr(6'h0C, 8'h3C);
      pulse(4'h8);
      rc(6'h0C, 8'h00);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    t_reset;
    t_trim;
    t_adc;
    t_count;
    report_and_stop;
  end
endmodule // atctr_regs_bench
